// *** verilog/mgb_mixer_regs.sv ***
// Purpose: Mixer gain, record source and beep generator register bank of an audio codec.
// Assumes: Register port strobes are synchronous one-cycle pulses on clk_sys.
// Notes: Outputs are registered; reads answer one cycle after the strobe.
`include "mgb_defs.svh"

module mgb_mixer_regs (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [6:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic [1:0] micBoostLevel,
  output logic [15:0] regRdData,
  output logic regRdValid,
  output logic [4:0] monoAtten,
  output logic monoOn,
  output logic [3:0] beepAtten,
  output logic beepTone,
  output logic beepAnalogPass,
  output logic beepResetBypass,
  output logic [4:0] phoneGain,
  output logic phoneOn,
  output logic [9:0] micGain,
  output logic [1:0] micOn,
  output logic [4:0] micBoostDb,
  output logic [9:0] lineGain,
  output logic [1:0] lineOn,
  output logic [9:0] cdGain,
  output logic [1:0] cdOn,
  output logic [9:0] auxGain,
  output logic [1:0] auxOn,
  output logic [9:0] dacGain,
  output logic [1:0] dacOn,
  output logic [2:0] leftRecordSource,
  output logic [2:0] rightRecordSource
);

  localparam logic [6:0] ADDR_TAB [`MGB_NREG] = '{`MGB_ADDR_MONO, `MGB_ADDR_BEEP, `MGB_ADDR_PHONE,
    `MGB_ADDR_MIC, `MGB_ADDR_LINE, `MGB_ADDR_CD, `MGB_ADDR_AUX, `MGB_ADDR_DAC, `MGB_ADDR_RECSRC};
  localparam logic [15:0] RST_TAB [`MGB_NREG] = '{`MGB_RST_MONO, `MGB_RST_BEEP, `MGB_RST_PHONE,
    `MGB_RST_STEREO, `MGB_RST_STEREO, `MGB_RST_STEREO, `MGB_RST_STEREO, `MGB_RST_STEREO, `MGB_RST_RECSRC};
  localparam logic [15:0] MASK_TAB [`MGB_NREG] = '{`MGB_MASK_MONO, `MGB_MASK_BEEP, `MGB_MASK_MONO,
    `MGB_MASK_MIC, `MGB_MASK_STEREO, `MGB_MASK_STEREO, `MGB_MASK_STEREO, `MGB_MASK_STEREO, `MGB_MASK_RECSRC};
  localparam logic [9:0] TICK_LAST = 10'(`MGB_TICK_CYC - 1);
  localparam logic [11:0] HALF_ONE = 12'(2 * `MGB_TICK_CYC - 1);
  localparam logic [11:0] HALF_TWO = 12'(4 * `MGB_TICK_CYC - 1);

  mgb_pkg::mgb_word_type regs_q [`MGB_NREG];
  logic [9:0] tickCnt_q;
  logic tick48k_q;
  logic [9:0] toneCnt_q;
  logic toneSq_q;
  logic [15:0] beepReg;
  logic [15:0] micReg;
  logic [7:0] beepDiv;
  logic [9:0] toneLast;
  logic toneSqSeen_q;
  logic [15:0] beepRegSeen_q;
  logic [11:0] toneGap_q;
  logic toneGapValid_q;
  logic toneFlip;
  logic beepRegMoved;
  logic toneGapOk;
  logic [9:0] tickGap_q;
  logic tickSeen_q;

  assign beepReg = regs_q[1];
  assign micReg = regs_q[3];
  assign beepDiv = beepReg[12:5];
  assign toneLast = {1'b0, beepDiv, 1'b0} - 10'h001;
  assign toneFlip = toneSq_q != toneSqSeen_q;
  assign beepRegMoved = beepReg != beepRegSeen_q;
  assign toneGapOk = toneGapValid_q & ~beepRegMoved;

  // Register writes, masked so reserved bits stay zero; a write to address 0x00 restores defaults.
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < `MGB_NREG; i++)
    begin
      if (!rstn || (regWrite && regAddr == `MGB_ADDR_RESET))
        regs_q[i] <= RST_TAB[i];
      else if (regWrite && regAddr == ADDR_TAB[i])
        regs_q[i] <= regWrData & MASK_TAB[i];
    end
  end

  // Register reads answer one cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      regRdData <= 16'h0000;
      regRdValid <= 1'b0;
    end
    else
    begin
      regRdValid <= regRead;
      if (regRead)
      begin
        regRdData <= (regAddr == `MGB_ADDR_RESET) ? `MGB_ID_CODE : 16'h0000;
        for (int i = 0; i < `MGB_NREG; i++)
        begin
          if (regAddr == ADDR_TAB[i])
            regRdData <= regs_q[i];
        end
      end
    end
  end

  // 48 kHz enable pulse derived from the system clock.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      tickCnt_q <= 10'h000;
      tick48k_q <= 1'b0;
    end
    else
    begin
      tick48k_q <= (tickCnt_q == TICK_LAST);
      tickCnt_q <= (tickCnt_q == TICK_LAST) ? 10'h000 : tickCnt_q + 10'h001;
    end
  end

  // Square wave toggles every 2N ticks, so the period is 4N ticks of 48 kHz.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || beepDiv == 8'h00)
    begin
      toneCnt_q <= 10'h000;
      toneSq_q <= 1'b0;
    end
    else if (tick48k_q)
    begin
      if (toneCnt_q >= toneLast)
      begin
        toneCnt_q <= 10'h000;
        toneSq_q <= ~toneSq_q;
      end
      else
        toneCnt_q <= toneCnt_q + 10'h001;
    end
  end

  // Beep routing: source select, mute and the reset bypass path.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      beepResetBypass <= 1'b1;
      beepTone <= 1'b0;
      beepAnalogPass <= 1'b0;
      beepAtten <= 4'h0;
    end
    else
    begin
      beepResetBypass <= 1'b0;
      beepTone <= toneSq_q & ~beepReg[`MGB_BIT_MUTE] & ~beepReg[`MGB_BIT_BEEP_SRC];
      beepAnalogPass <= ~beepReg[`MGB_BIT_MUTE] & beepReg[`MGB_BIT_BEEP_SRC];
      beepAtten <= beepReg[4:1];
    end
  end

  // Mixer path controls; a mute bit clears the channel enable whatever the gain holds.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      monoAtten <= 5'h00;
      monoOn <= 1'b0;
      phoneGain <= 5'h08;
      phoneOn <= 1'b0;
      micGain <= 10'h108;
      micOn <= 2'h0;
      lineGain <= 10'h108;
      lineOn <= 2'h0;
      cdGain <= 10'h108;
      cdOn <= 2'h0;
      auxGain <= 10'h108;
      auxOn <= 2'h0;
      dacGain <= 10'h108;
      dacOn <= 2'h0;
      leftRecordSource <= 3'h0;
      rightRecordSource <= 3'h0;
    end
    else
    begin
      monoAtten <= regs_q[0][4:0];
      monoOn <= ~regs_q[0][`MGB_BIT_MUTE];
      phoneGain <= regs_q[2][4:0];
      phoneOn <= ~regs_q[2][`MGB_BIT_MUTE];
      micGain <= {micReg[12:8], micReg[4:0]};
      micOn <= {~micReg[`MGB_BIT_MUTE], ~micReg[`MGB_BIT_RMUTE]};
      lineGain <= {regs_q[4][12:8], regs_q[4][4:0]};
      lineOn <= {~regs_q[4][`MGB_BIT_MUTE], ~regs_q[4][`MGB_BIT_RMUTE]};
      cdGain <= {regs_q[5][12:8], regs_q[5][4:0]};
      cdOn <= {~regs_q[5][`MGB_BIT_MUTE], ~regs_q[5][`MGB_BIT_RMUTE]};
      auxGain <= {regs_q[6][12:8], regs_q[6][4:0]};
      auxOn <= {~regs_q[6][`MGB_BIT_MUTE], ~regs_q[6][`MGB_BIT_RMUTE]};
      dacGain <= {regs_q[7][12:8], regs_q[7][4:0]};
      dacOn <= {~regs_q[7][`MGB_BIT_MUTE], ~regs_q[7][`MGB_BIT_RMUTE]};
      leftRecordSource <= regs_q[8][10:8];
      rightRecordSource <= regs_q[8][2:0];
    end
  end

  // Microphone boost in dB; software keeps it off for line-level sources.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      micBoostDb <= 5'h00;
    else if (!micReg[`MGB_BIT_BOOST])
      micBoostDb <= 5'h00;
    else
    begin
      case (mgb_pkg::mgb_boost_type'(micBoostLevel))
        mgb_pkg::MGB_BOOST_20DB: micBoostDb <= 5'h14;
        mgb_pkg::MGB_BOOST_10DB: micBoostDb <= 5'h0A;
        default: micBoostDb <= 5'h1E;
      endcase
    end
  end

  // Checker helpers measure tone toggle and 48 kHz pulse spacing apart from the divider logic.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      toneSqSeen_q <= 1'b0;
      beepRegSeen_q <= `MGB_RST_BEEP;
    end
    else
    begin
      toneSqSeen_q <= toneSq_q;
      beepRegSeen_q <= beepReg;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn || toneFlip || beepRegMoved)
      toneGap_q <= 12'h000;
    else if (toneGap_q != 12'hFFF)
      toneGap_q <= toneGap_q + 12'h001;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn || beepRegMoved)
      toneGapValid_q <= 1'b0;
    else if (toneFlip)
      toneGapValid_q <= 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn || tick48k_q)
      tickGap_q <= 10'h000;
    else
      tickGap_q <= tickGap_q + 10'h001;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      tickSeen_q <= 1'b0;
    else if (tick48k_q)
      tickSeen_q <= 1'b1;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_mono_reset_value: assert property ($rose(rstn) |-> regs_q[0] == 16'h8000 && regs_q[1] == 16'h8000)
    else $error("Mono or beep register default wrong.");
  a_reset_write_defaults: assert property (regWrite && regAddr == 7'h00 |=> regs_q[2] == 16'h8008 && regs_q[3] == 16'h8888 && regs_q[8] == 16'h0000)
    else $error("Reset register write did not restore defaults.");
  a_reserved_read_zero: assert property (regRead && regAddr == `MGB_ADDR_MIC |=>
    regRdValid && (regRdData & ~`MGB_MASK_MIC) == 16'h0000)
    else $error("Reserved bit read back nonzero.");
  a_write_masked: assert property (regWrite && regAddr == `MGB_ADDR_BEEP |=>
    beepReg == ($past(regWrData) & `MGB_MASK_BEEP))
    else $error("Beep register write not masked.");
  a_id_read_value: assert property (regRead && regAddr == `MGB_ADDR_RESET |=> regRdData == `MGB_ID_CODE)
    else $error("Reset register read value wrong.");
  a_beep_mute_silent: assert property (regs_q[1][15] |=> !beepTone && !beepAnalogPass)
    else $error("Muted beep still audible.");
  a_beep_src_analog: assert property (regs_q[1][15:14] == 2'b01 |=> beepAnalogPass && !beepTone)
    else $error("Analog beep source not passed.");
  a_tone_disabled_quiet: assert property (regs_q[1][12:5] == 8'h00 |=> !toneSq_q)
    else $error("Tone runs with zero divider.");
  a_tone_half_one: assert property (toneFlip && toneGapOk && beepDiv == 8'h01 |-> toneGap_q == HALF_ONE)
    else $error("Tone half period wrong for divider one.");
  a_tone_half_two: assert property (toneFlip && toneGapOk && beepDiv == 8'h02 |-> toneGap_q == HALF_TWO)
    else $error("Tone half period wrong for divider two.");
  a_tick_spacing: assert property (tick48k_q && tickSeen_q |-> tickGap_q == TICK_LAST)
    else $error("Tone base pulse spacing wrong.");
  a_beep_level_follow: assert property (beepAtten == $past(beepReg[4:1]))
    else $error("Beep level output does not follow its field.");
  a_mono_mute_off: assert property (regs_q[0][`MGB_BIT_MUTE] |=> !monoOn)
    else $error("Muted mono output still enabled.");
  a_phone_mute_off: assert property (regs_q[2][`MGB_BIT_MUTE] |=> !phoneOn)
    else $error("Muted phone input still enabled.");
  a_line_mute_off: assert property (regs_q[4][`MGB_BIT_MUTE] |=> !lineOn[1])
    else $error("Muted left line input still enabled.");
  a_cd_mute_off: assert property (regs_q[5][`MGB_BIT_RMUTE] |=> !cdOn[0])
    else $error("Muted right cd input still enabled.");
  a_aux_mute_off: assert property (regs_q[6][`MGB_BIT_MUTE] |=> !auxOn[1])
    else $error("Muted left aux input still enabled.");
  a_dac_mute_off: assert property (regs_q[7][`MGB_BIT_RMUTE] |=> !dacOn[0])
    else $error("Muted right front DAC still enabled.");
  a_record_follow: assert property (leftRecordSource == $past(regs_q[8][10:8])
    && rightRecordSource == $past(regs_q[8][2:0]))
    else $error("Record source outputs do not follow the register.");
  a_mic_mute_off: assert property (regs_q[3][7] |=> !micOn[0])
    else $error("Muted right mic still enabled.");
  a_boost_disabled_zero: assert property (!regs_q[3][6] |=> micBoostDb == 5'h00)
    else $error("Boost applied while disabled.");
  a_boost_level_twenty: assert property (micReg[`MGB_BIT_BOOST] && micBoostLevel == 2'h0 |=> micBoostDb == 5'h14)
    else $error("Boost level select zero not 20 dB.");
  a_bypass_after_reset: assert property (disable iff (1'b0) !rstn |=> beepResetBypass)
    else $error("Beep bypass not active in reset.");

  c_beep_digital: cover property (beepTone ##1 !beepTone);
  c_reset_write: cover property (regWrite && regAddr == 7'h00);
  c_boost_30: cover property (micBoostDb == 5'h1E);
  c_tone_half_two: cover property (toneFlip && toneGapOk && beepDiv == 8'h02);
  c_analog_pass: cover property (beepAnalogPass);

endmodule // mgb_mixer_regs

// *** verilog/mgb_defs.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the mixer gain and beep bank.
// Assumes: 16-bit registers reached by their printed offsets on a 7-bit register port.
// Notes: Definitions only.
`ifndef MGB_DEFS_SVH
`define MGB_DEFS_SVH

`define MGB_NREG 9
`define MGB_ADDR_RESET 7'h00
`define MGB_ADDR_MONO 7'h06
`define MGB_ADDR_BEEP 7'h0A
`define MGB_ADDR_PHONE 7'h0C
`define MGB_ADDR_MIC 7'h0E
`define MGB_ADDR_LINE 7'h10
`define MGB_ADDR_CD 7'h12
`define MGB_ADDR_AUX 7'h16
`define MGB_ADDR_DAC 7'h18
`define MGB_ADDR_RECSRC 7'h1A

`define MGB_RST_MONO 16'h8000
`define MGB_RST_BEEP 16'h8000
`define MGB_RST_PHONE 16'h8008
`define MGB_RST_STEREO 16'h8888
`define MGB_RST_RECSRC 16'h0000

`define MGB_MASK_MONO 16'h801F
`define MGB_MASK_BEEP 16'hDFFE
`define MGB_MASK_MIC 16'h9FDF
`define MGB_MASK_STEREO 16'h9F9F
`define MGB_MASK_RECSRC 16'h0707

// Arbitrary identification value returned by the reset register.
`define MGB_ID_CODE 16'h0000

`define MGB_BIT_MUTE 15
`define MGB_BIT_BEEP_SRC 14
`define MGB_BIT_RMUTE 7
`define MGB_BIT_BOOST 6

`define MGB_SYS_HZ 25000000
`define MGB_TICK_HZ 48000
`define MGB_TICK_CYC ((`MGB_SYS_HZ) / (`MGB_TICK_HZ))

`endif

// *** verilog/mgb_pkg.sv ***
// Purpose: Types shared by the mixer gain and beep bank.
// Assumes: Constants live in mgb_defs.svh.
// Notes: Nothing here is imported; users write mgb_pkg::name.
package mgb_pkg;

  typedef logic [15:0] mgb_word_type;

  typedef enum logic [1:0] {
    MGB_BOOST_20DB,
    MGB_BOOST_10DB,
    MGB_BOOST_30DB,
    MGB_BOOST_30DB_ALT
  } mgb_boost_type;

endpackage

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for the mixer gain and beep register bank.
// Assumes: 25 MHz clk_sys and a synchronous active-low rstn.
// Notes: Expected values come from the register table constants and hand counts.
`include "mgb_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rstn, regWrite, regRead, regRdValid, monoOn, beepTone, beepAnalogPass, beepResetBypass, phoneOn;
  logic [6:0] regAddr;
  logic [15:0] regWrData, regRdData;
  logic [1:0] micBoostLevel, micOn, lineOn, cdOn, auxOn, dacOn;
  logic [4:0] monoAtten, phoneGain, micBoostDb;
  logic [3:0] beepAtten;
  logic [9:0] micGain, lineGain, cdGain, auxGain, dacGain;
  logic [2:0] leftRecordSource, rightRecordSource;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [6:0] addrTab [9] = '{`MGB_ADDR_MONO, `MGB_ADDR_BEEP, `MGB_ADDR_PHONE, `MGB_ADDR_MIC, `MGB_ADDR_LINE,
    `MGB_ADDR_CD, `MGB_ADDR_AUX, `MGB_ADDR_DAC, `MGB_ADDR_RECSRC};
  logic [15:0] rstTab [9] = '{16'h8000, 16'h8000, 16'h8008, 16'h8888, 16'h8888, 16'h8888, 16'h8888, 16'h8888, 16'h0000};
  logic [15:0] maskTab [9] = '{16'h801F, 16'hDFFE, 16'h801F, 16'h9FDF, 16'h9F9F, 16'h9F9F, 16'h9F9F, 16'h9F9F, 16'h0707};
  logic [4:0] boostTab [4] = '{5'h14, 5'h0A, 5'h1E, 5'h1E};

  mgb_mixer_regs uut (.clk_sys(clk_sys), .rstn(rstn), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWrData(regWrData), .micBoostLevel(micBoostLevel), .regRdData(regRdData), .regRdValid(regRdValid),
    .monoAtten(monoAtten), .monoOn(monoOn), .beepAtten(beepAtten), .beepTone(beepTone),
    .beepAnalogPass(beepAnalogPass), .beepResetBypass(beepResetBypass), .phoneGain(phoneGain), .phoneOn(phoneOn),
    .micGain(micGain), .micOn(micOn), .micBoostDb(micBoostDb), .lineGain(lineGain), .lineOn(lineOn),
    .cdGain(cdGain), .cdOn(cdOn), .auxGain(auxGain), .auxOn(auxOn), .dacGain(dacGain), .dacOn(dacOn),
    .leftRecordSource(leftRecordSource), .rightRecordSource(rightRecordSource));

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    chk(16'(regRdValid), 16'h0001);
    d = regRdData;
  endtask

  task automatic t_defaults();
    logic [15:0] v;
    for (int i = 0; i < 9; i++)
    begin
      rd(addrTab[i], v);
      chk(v, rstTab[i]);
    end
    rd(7'h02, v);
    chk(v, 16'h0000);
    rd(`MGB_ADDR_RESET, v);
    chk(v, `MGB_ID_CODE);
    $display("defaults done");
  endtask

  task automatic t_masks();
    logic [15:0] v;
    for (int i = 0; i < 9; i++)
    begin
      wr(addrTab[i], 16'hFFFF);
      rd(addrTab[i], v);
      chk(v, maskTab[i]);
    end
    chk(16'({monoOn, phoneOn, micOn, beepAnalogPass}), 16'h0000);
    chk(16'(micBoostDb), 16'h0014);
    wr(`MGB_ADDR_RESET, 16'h1234);
    $display("masks done");
  endtask

  task automatic t_decode();
    wr(`MGB_ADDR_MONO, 16'h001F);
    chk(16'({monoOn, monoAtten}), 16'h003F);
    wr(`MGB_ADDR_PHONE, 16'h0000);
    chk(16'({phoneOn, phoneGain}), 16'h0020);
    wr(`MGB_ADDR_LINE, 16'h0108);
    chk(16'({lineOn, lineGain}), 16'h0C28);
    wr(`MGB_ADDR_CD, 16'h8005);
    chk(16'({cdOn, cdGain}), 16'h0405);
    wr(`MGB_ADDR_DAC, 16'h0A80);
    chk(16'({dacOn, dacGain}), 16'h0940);
    wr(`MGB_ADDR_AUX, 16'h9F1F);
    chk(16'({auxOn, auxGain}), 16'h07FF);
    wr(`MGB_ADDR_MIC, 16'h0303);
    chk(16'({micOn, micGain}), 16'h0C63);
    chk(16'(micBoostDb), 16'h0000);
    chk(16'({leftRecordSource, rightRecordSource}), 16'h0000);
    wr(`MGB_ADDR_RECSRC, 16'h0102);
    chk(16'({leftRecordSource, rightRecordSource}), 16'h000A);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      micBoostLevel <= 2'(i);
      wr(`MGB_ADDR_MIC, 16'h0848);
      chk(16'(micBoostDb), 16'(boostTab[i]));
    end
    $display("decode done");
  endtask

  task automatic wait_edge(output int n);
    logic prev;
    n = 0;
    prev = beepTone;
    while (beepTone === prev && n < 3000)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask

  task automatic t_beep();
    int n;
    wr(`MGB_ADDR_BEEP, 16'h401E);
    chk(16'({beepAnalogPass, beepTone, beepAtten}), 16'h002F);
    wr(`MGB_ADDR_BEEP, 16'hC01E);
    chk(16'(beepAnalogPass), 16'h0000);
    wr(`MGB_ADDR_BEEP, 16'h0020);
    chk(16'(beepAnalogPass), 16'h0000);
    wait_edge(n);
    wait_edge(n);
    chk(16'(n), 16'h0410);
    wr(`MGB_ADDR_BEEP, 16'h0040);
    wait_edge(n);
    wait_edge(n);
    chk(16'(n), 16'h0820);
    wr(`MGB_ADDR_BEEP, 16'h8040);
    wait_edge(n);
    chk(16'({beepTone, 15'(n)}), 16'h0BB8);
    wr(`MGB_ADDR_BEEP, 16'h0000);
    wait_edge(n);
    chk(16'({beepTone, 15'(n)}), 16'h0BB8);
    $display("beep done");
  endtask

  initial
  begin
    rstn = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 7'h00;
    regWrData = 16'h0000;
    micBoostLevel = 2'b00;
    repeat (15) @(posedge clk_sys);
    #1;
    chk(16'(beepResetBypass), 16'h0001);
    @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk(16'(beepResetBypass), 16'h0000);
    t_defaults();
    t_masks();
    t_defaults();
    t_decode();
    t_beep();
    final_report();
  end
endmodule // testbench
